// ===== fste_fan_model.sv
/*
  Two-pole fan tach model: the pin toggles every half_i cycles while run_i is high.
  Assumes the bench clock; the pin stands still when the fan is stopped.
*/
module fste_fan_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [15:0] half_i,
    output logic tach_o
);
    logic [15:0] cnt_ff;
    // evenly spaced edges: 5 of them span one turn, 3 span half a turn
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_ff <= 16'h0;
            tach_o <= rst_i ? 1'b1 : tach_o;
        end else if (cnt_ff == half_i - 16'h1) begin
            cnt_ff <= 16'h0;
            tach_o <= !tach_o;
        end else begin
            cnt_ff <= cnt_ff + 16'h1;
        end
    end
endmodule // fste_fan_model

// ===== fste_fan_status.sv
/*
  Fan status and tachometer edge block: sticky condition flags, stall and
  shortfall detection, spin-up supervision, register port and interrupt.
  Assumes an 8-bit register master with one-cycle strobes and a drive
  high byte supplied by the speed control algorithm on the same clock.
*/
// Strobed register access was chosen for this implementation.
module fste_fan_status #(
    parameter int unsigned SPIN_CYCLES = fste_pkg::SPIN_CYCLES
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WR_DATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RD_DATA_O,
    input wire logic TACH_I,
    input wire logic [7:0] DRIVE_HI_I,
    output logic SPIN_UP_O,
    output logic IRQ_O
);

    // ==========================================================
    // register storage
    logic [7:0] status_ff, ctrl_ff, limit_ff, target_ff, band_ff, irq_en_ff;
    logic [12:0] reading_ff;
    logic [7:0] rd_data_ff;
    logic irq_ff;

    // ==========================================================
    // write decode
    logic wr_status, wr_clear, wr_ctrl, wr_limit, wr_target, wr_band, wr_irq_en;
    assign wr_status = WR_I && (ADDR_I == fste_pkg::OFS_STATUS);
    assign wr_clear = WR_I && (ADDR_I == fste_pkg::OFS_CLEAR);
    assign wr_ctrl = WR_I && (ADDR_I == fste_pkg::OFS_CTRL);
    assign wr_limit = WR_I && (ADDR_I == fste_pkg::OFS_LIMIT);
    assign wr_target = WR_I && (ADDR_I == fste_pkg::OFS_TARGET);
    assign wr_band = WR_I && (ADDR_I == fste_pkg::OFS_BAND);
    assign wr_irq_en = WR_I && (ADDR_I == fste_pkg::OFS_IRQ_EN);

    // control fields
    logic algo_en, three_edge;
    logic [1:0] dur_sel;
    assign algo_en = ctrl_ff[fste_pkg::CT_ALGO_EN];
    assign three_edge = ctrl_ff[fste_pkg::CT_THREE_EDGE];
    assign dur_sel = ctrl_ff[fste_pkg::CT_DUR_LO +: 2];

    // ==========================================================
    // tachometer measurement
    fste_pkg::tach_meas_s meas;

    fste_tach_meter u_meter (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .tach_i(TACH_I),
        .three_edge_i(three_edge),
        .meas_o(meas)
    );

    // ==========================================================
    // stall detection: limit widened to 13 bits with zero low bits
    logic [12:0] limit_cnt;
    logic stall_evt;
    assign limit_cnt = {limit_ff, 5'h00};
    assign stall_evt = meas.valid && (meas.saturated || meas.count > limit_cnt);

    // ==========================================================
    // shortfall: a larger count is a slower fan, so target minus band in
    // speed is target plus band in count
    logic [13:0] fail_level;
    logic full_drive, slow_evt;
    logic [7:0] fail_cnt_ff, nxt_fail_cnt, fail_goal;
    logic drive_evt;
    assign fail_level = {1'b0, target_ff, 5'h00} + {1'b0, band_ff, 5'h00};
    assign full_drive = (DRIVE_HI_I == fste_pkg::DRIVE_FULL);
    assign slow_evt = meas.valid && ({1'b0, meas.count} > fail_level || meas.saturated);
    assign fail_goal = fste_pkg::FAIL_BASE << dur_sel;
    // runs counted per measurement; any fast result or drive below full restarts it
    assign nxt_fail_cnt = !(full_drive && algo_en) ? 8'h00 :
                          !meas.valid ? fail_cnt_ff :
                          !slow_evt ? 8'h00 :
                          (fail_cnt_ff == fail_goal) ? fail_cnt_ff : fail_cnt_ff + 8'h01;
    assign drive_evt = slow_evt && full_drive && algo_en && (fail_cnt_ff == fail_goal - 8'h01);

    always_ff @(posedge CLK_I) begin
        fail_cnt_ff <= RST_I ? 8'h00 : nxt_fail_cnt;
    end

    // ==========================================================
    // spin-up supervision
    fste_pkg::spin_state_e spin_ff, nxt_spin;
    logic [31:0] spin_cnt_ff;
    logic spin_timeout, spin_ok;
    assign spin_ok = meas.valid && !stall_evt;
    assign spin_timeout = (spin_ff == fste_pkg::SPIN_RUN) && !spin_ok &&
                          (spin_cnt_ff == SPIN_CYCLES - 1);

    always_comb begin
        nxt_spin = spin_ff;
        unique case (spin_ff)
            fste_pkg::SPIN_IDLE: begin
                if (stall_evt && algo_en) begin
                    nxt_spin = fste_pkg::SPIN_RUN;
                end
            end
            fste_pkg::SPIN_RUN: begin
                if (spin_ok || spin_timeout) begin
                    nxt_spin = fste_pkg::SPIN_IDLE;
                end
            end
            default: nxt_spin = fste_pkg::SPIN_IDLE;
        endcase
    end

    // the timer only runs inside a window; a fresh stall after a timeout retries
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            spin_ff <= fste_pkg::SPIN_IDLE;
            spin_cnt_ff <= 32'h0000_0000;
        end else begin
            spin_ff <= nxt_spin;
            spin_cnt_ff <= (nxt_spin == fste_pkg::SPIN_RUN && spin_ff == fste_pkg::SPIN_RUN) ?
                           spin_cnt_ff + 32'h0000_0001 : 32'h0000_0000;
        end
    end

    // ==========================================================
    // sticky flags: set wins over a clear in the same cycle
    logic [7:0] flag_set, flag_clr, nxt_status;
    assign flag_set = {2'b00, drive_evt, 3'b000, spin_timeout, stall_evt};
    assign flag_clr = (wr_status || wr_clear) ? WR_DATA_I : 8'h00;
    assign nxt_status = ((status_ff & ~flag_clr) | flag_set) & fste_pkg::ST_MASK;

    // ==========================================================
    // software registers
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            status_ff <= fste_pkg::RST_STATUS;
            ctrl_ff <= fste_pkg::RST_CTRL;
            limit_ff <= fste_pkg::RST_LIMIT;
            target_ff <= fste_pkg::RST_TARGET;
            band_ff <= fste_pkg::RST_BAND;
            irq_en_ff <= fste_pkg::RST_IRQ_EN;
            reading_ff <= 13'h0000;
        end else begin
            status_ff <= nxt_status;
            ctrl_ff <= wr_ctrl ? (WR_DATA_I & fste_pkg::CT_MASK) : ctrl_ff;
            limit_ff <= wr_limit ? WR_DATA_I : limit_ff;
            target_ff <= wr_target ? WR_DATA_I : target_ff;
            band_ff <= wr_band ? WR_DATA_I : band_ff;
            irq_en_ff <= wr_irq_en ? (WR_DATA_I & fste_pkg::ST_MASK) : irq_en_ff;
            reading_ff <= meas.valid ? meas.count : reading_ff;
        end
    end

    // ==========================================================
    // read selection; unmapped and write-only offsets read zero
    logic [7:0] rd_mux;
    assign rd_mux = (ADDR_I == fste_pkg::OFS_STATUS) ? status_ff :
                    (ADDR_I == fste_pkg::OFS_CTRL) ? ctrl_ff :
                    (ADDR_I == fste_pkg::OFS_LIMIT) ? limit_ff :
                    (ADDR_I == fste_pkg::OFS_TARGET) ? target_ff :
                    (ADDR_I == fste_pkg::OFS_BAND) ? band_ff :
                    (ADDR_I == fste_pkg::OFS_READ_HI) ? reading_ff[12:5] :
                    (ADDR_I == fste_pkg::OFS_READ_LO) ? {reading_ff[4:0], 3'b000} :
                    (ADDR_I == fste_pkg::OFS_IRQ_EN) ? irq_en_ff : 8'h00;

    // read data stand only in the cycle after the strobe
    always_ff @(posedge CLK_I) begin
        rd_data_ff <= (RST_I || !RD_I) ? 8'h00 : rd_mux;
        irq_ff <= RST_I ? 1'b0 : |(nxt_status & irq_en_ff);
    end

    assign RD_DATA_O = rd_data_ff;
    assign IRQ_O = irq_ff;
    assign SPIN_UP_O = spin_ff[1];

endmodule // fste_fan_status

// ===== fste_fan_status_checker.sv
/*
  Concurrent checks on the fan status block, seen from its top ports.
  Assumes one clock CLK_I and the synchronous reset RST_I.
*/
module fste_fan_status_checker #(
    parameter int unsigned SPIN_CYCLES = 20000
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WR_DATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RD_DATA_O,
    input wire logic TACH_I,
    input wire logic [7:0] DRIVE_HI_I,
    input wire logic SPIN_UP_O,
    input wire logic IRQ_O
);
    // ==========================================================
    // helpers
    logic [31:0] spin_cnt_ff;
    logic [3:0] quiet_ff;
    logic tach_d_ff;
    // spin length, and cycles since a tach change; quiet saturates so it never wraps back to small
    always_ff @(posedge CLK_I) begin
        tach_d_ff <= TACH_I;
        spin_cnt_ff <= (RST_I || !SPIN_UP_O) ? 32'h0 : spin_cnt_ff + 32'h1;
        quiet_ff <= (TACH_I != tach_d_ff) ? 4'h0 : ((quiet_ff == 4'hf) ? quiet_ff : quiet_ff + 4'h1);
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // ==========================================================
    // properties
    property p_rd_idle; !$past(RD_I) |-> RD_DATA_O == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
    property p_rst_out; $fell(RST_I) |-> !IRQ_O && !SPIN_UP_O; endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs up after reset");
    property p_rsvd; $past(RD_I) && $past(ADDR_I) == fste_pkg::OFS_STATUS |-> (RD_DATA_O & 8'hdc) == 8'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");
    property p_clr_rd; $past(RD_I) && $past(ADDR_I) == fste_pkg::OFS_CLEAR |-> RD_DATA_O == 8'h00; endproperty
    a_clr_rd: assert property (p_clr_rd) else $error("clear register readable");
    property p_irq_mask; WR_I && ADDR_I == fste_pkg::OFS_IRQ_EN && WR_DATA_I == 8'h00 |-> ##2 !IRQ_O; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt while all masked");
    property p_irq_src; RD_I && ADDR_I == fste_pkg::OFS_STATUS && IRQ_O && !$past(WR_I) |=> RD_DATA_O != 8'h00; endproperty
    a_irq_src: assert property (p_irq_src) else $error("interrupt with empty status");
    property p_spin_max; spin_cnt_ff <= SPIN_CYCLES + 2; endproperty
    a_spin_max: assert property (p_spin_max) else $error("spin-up window too long");
    property p_spin_cause; $rose(SPIN_UP_O) |-> quiet_ff < 4'hc; endproperty
    a_spin_cause: assert property (p_spin_cause) else $error("spin-up without a tach result");
    // a local variable keeps the written limit across the gap to the read
    property p_limit_rw;
        logic [7:0] v;
        (WR_I && ADDR_I == fste_pkg::OFS_LIMIT, v = WR_DATA_I) ##1 !WR_I ##1 (RD_I && ADDR_I == fste_pkg::OFS_LIMIT)
        |=> RD_DATA_O == v;
    endproperty
    a_limit_rw: assert property (p_limit_rw) else $error("limit read back wrong");
    c_spin: cover property ($rose(SPIN_UP_O));
    c_irq: cover property ($rose(IRQ_O));
    c_cnt: cover property (RD_I && ADDR_I == fste_pkg::OFS_READ_HI);
endmodule // fste_fan_status_checker

bind fste_fan_status fste_fan_status_checker #(.SPIN_CYCLES(SPIN_CYCLES)) fste_fan_status_checker_i (
    .CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I), .WR_I(WR_I), .RD_I(RD_I),
    .RD_DATA_O(RD_DATA_O), .TACH_I(TACH_I), .DRIVE_HI_I(DRIVE_HI_I), .SPIN_UP_O(SPIN_UP_O), .IRQ_O(IRQ_O));

// ===== fste_pkg.sv
/*
  Package for the fan status and tachometer edge block: register map,
  field positions, reset values, timing counts and shared types.
  Assumes a single 25 MHz system clock and an 8-bit register port.
*/
package fste_pkg;

    // ==========================================================
    // clock and timing
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned TACH_HZ = 32768;                     // tach measurement clock
    localparam int unsigned TICK_DIV = CLK_HZ / TACH_HZ;         // cycles per measurement tick
    localparam int unsigned SPIN_TIME_MS = 1000;                 // longest spin-up window
    localparam int unsigned SPIN_CYCLES = SPIN_TIME_MS * (CLK_HZ / 1000);

    // ==========================================================
    // register offsets
    localparam logic [7:0] OFS_STATUS = 8'h11;
    localparam logic [7:0] OFS_CTRL = 8'h20;
    localparam logic [7:0] OFS_LIMIT = 8'h21;
    localparam logic [7:0] OFS_TARGET = 8'h22;
    localparam logic [7:0] OFS_BAND = 8'h23;
    localparam logic [7:0] OFS_READ_HI = 8'h24;
    localparam logic [7:0] OFS_READ_LO = 8'h25;
    localparam logic [7:0] OFS_IRQ_EN = 8'h26;
    localparam logic [7:0] OFS_CLEAR = 8'h27;

    // ==========================================================
    // field positions
    localparam int unsigned ST_STALL = 0;
    localparam int unsigned ST_SPIN = 1;
    localparam int unsigned ST_DRIVE = 5;
    localparam logic [7:0] ST_MASK = 8'h23;                      // only bits 5, 1, 0 exist
    localparam int unsigned CT_ALGO_EN = 0;
    localparam int unsigned CT_THREE_EDGE = 1;
    localparam int unsigned CT_DUR_LO = 2;                       // duration select in bits 3:2
    localparam logic [7:0] CT_MASK = 8'h0f;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_LIMIT = 8'hf5;
    localparam logic [7:0] RST_TARGET = 8'h00;
    localparam logic [7:0] RST_BAND = 8'h00;
    localparam logic [7:0] RST_IRQ_EN = 8'h00;

    // ==========================================================
    // measurement constants
    localparam int unsigned CNT_W = 13;
    localparam logic [12:0] CNT_MAX = 13'h1fff;
    localparam logic [2:0] EDGES_FULL = 3'h5;                    // full revolution, two-pole fan
    localparam logic [2:0] EDGES_HALF = 3'h3;                    // half revolution
    localparam logic [7:0] FAIL_BASE = 8'h10;                    // shortfall runs, shifted by select
    localparam logic [7:0] DRIVE_FULL = 8'hff;

    // one finished measurement from the tach meter
    typedef struct packed {
        logic valid;
        logic saturated;
        logic [12:0] count;
    } tach_meas_s;

    typedef enum logic [1:0] {
        SPIN_IDLE = 2'b01,
        SPIN_RUN = 2'b10
    } spin_state_e;

endpackage

// ===== fste_tach_meter.sv
/*
  Tachometer edge meter: synchronises the tach pin, counts measurement ticks
  across 5 or 3 tach edges and reports one result per window.
  Assumes the tach pin is asynchronous to CLK_I.
*/
module fste_tach_meter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tach_i,
    input wire logic three_edge_i,
    output fste_pkg::tach_meas_s meas_o
);

    // ==========================================================
    // three-stage synchroniser and level filter
    logic s1_ff, s2_ff, s3_ff, lvl_ff;
    logic agree, edge_seen;
    assign agree = (s2_ff == s3_ff);
    assign edge_seen = agree && (s3_ff != lvl_ff);

    always_ff @(posedge clk_i) begin
        s1_ff <= tach_i;
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        // follow the pin in reset too, so an idle-high tach gives no false edge afterwards
        lvl_ff <= (rst_i || agree) ? s3_ff : lvl_ff;
    end

    // ==========================================================
    // measurement tick and edge window
    logic [9:0] div_ff;
    logic [2:0] edges_ff;
    logic [12:0] cnt_ff;
    fste_pkg::tach_meas_s meas_ff;
    logic tick, last_edge, sat;
    logic [2:0] edge_goal;

    assign tick = (div_ff == 10'(fste_pkg::TICK_DIV - 1));
    assign edge_goal = three_edge_i ? fste_pkg::EDGES_HALF : fste_pkg::EDGES_FULL;
    // at or past the goal: a mode change mid-window must not let the edge count wrap
    assign last_edge = edge_seen && (edges_ff != 3'h0) && (edges_ff >= edge_goal - 3'h1);
    // a fan that stops leaves the counter pinned; report it as saturated
    assign sat = tick && (cnt_ff == fste_pkg::CNT_MAX) && (edges_ff != 3'h0);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_ff <= 10'h000;
            edges_ff <= 3'h0;
            cnt_ff <= 13'h0000;
            meas_ff <= '0;
        end else begin
            div_ff <= tick ? 10'h000 : div_ff + 10'h001;
            meas_ff.valid <= last_edge || sat;
            meas_ff.saturated <= sat && !last_edge;
            if (last_edge || sat) begin
                meas_ff.count <= cnt_ff;
            end
            if (last_edge) begin
                edges_ff <= 3'h1;                    // closing edge opens the next window
                cnt_ff <= 13'h0000;
            end else if (sat) begin
                edges_ff <= 3'h0;
                cnt_ff <= 13'h0000;
            end else begin
                if (edge_seen) begin
                    edges_ff <= edges_ff + 3'h1;
                end
                if (tick && edges_ff != 3'h0) begin
                    cnt_ff <= cnt_ff + 13'h0001;
                end
            end
        end
    end

    assign meas_o = meas_ff;

endmodule // fste_tach_meter

// ===== testbench.sv
/*
  Self-checking bench for the fan status block with a tach model on its pin.
  Assumes the checker file is compiled with the design.
*/
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned SPIN = 20000;
    logic clk, rst, wr, rd, run, tach, spin, irq;
    logic [7:0] addr, wd, rdd, drive;
    logic [15:0] half;
    int fails, n_checks;
    // ==========================================================
    // clock, design and fan
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    fste_fan_status #(.SPIN_CYCLES(SPIN)) fste_fan_status_i (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
        .WR_DATA_I(wd), .WR_I(wr), .RD_I(rd), .RD_DATA_O(rdd), .TACH_I(tach), .DRIVE_HI_I(drive),
        .SPIN_UP_O(spin), .IRQ_O(irq));
    fste_fan_model fste_fan_model_i (.clk_i(clk), .rst_i(rst), .run_i(run), .half_i(half), .tach_o(tach));
    // ==========================================================
    // bus cycles and comparison
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdd;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd_reg(a, d);
        chk8(d, exp);
    endtask
    task automatic rd_cnt(output logic [12:0] c);
        logic [7:0] h, l;
        rd_reg(fste_pkg::OFS_READ_HI, h);
        rd_reg(fste_pkg::OFS_READ_LO, l);
        c = {h, l[7:3]};
    endtask
    task automatic give_verdict;
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset;
        rd_chk(fste_pkg::OFS_STATUS, 8'h00);
        rd_chk(fste_pkg::OFS_LIMIT, 8'hf5);
        rd_chk(fste_pkg::OFS_IRQ_EN, 8'h00);
        rd_chk(fste_pkg::OFS_CLEAR, 8'h00);
        rd_chk(8'h3c, 8'h00);
        wr_reg(fste_pkg::OFS_STATUS, 8'hff);
        rd_chk(fste_pkg::OFS_STATUS, 8'h00);
        wr_reg(fste_pkg::OFS_LIMIT, 8'h5a);
        rd_chk(fste_pkg::OFS_LIMIT, 8'h5a);
    endtask
    // 1524-cycle half periods: four gaps are 8 ticks of 762, two gaps 4 ticks, give or take one
    task automatic t_edges;
        logic [12:0] c;
        wr_reg(fste_pkg::OFS_LIMIT, 8'hff);
        half <= 16'd1524;
        run <= 1'b1;
        repeat (8 * 1524) @(posedge clk);
        rd_cnt(c);
        chk8({7'h0, c >= 13'd7 && c <= 13'd9}, 8'h01);
        wr_reg(fste_pkg::OFS_CTRL, 8'h02);
        repeat (6 * 1524) @(posedge clk);
        rd_cnt(c);
        chk8({7'h0, c >= 13'd3 && c <= 13'd5}, 8'h01);
        run <= 1'b0;
    endtask
    task automatic t_stall_spin;
        int i;
        wr_reg(fste_pkg::OFS_LIMIT, 8'h00);
        wr_reg(fste_pkg::OFS_IRQ_EN, 8'h01);
        wr_reg(fste_pkg::OFS_CTRL, 8'h01);
        half <= 16'd400;
        run <= 1'b1;
        for (i = 0; i < 4000 && spin !== 1'b1; i++) @(posedge clk);
        run <= 1'b0;
        chk8({7'h0, spin}, 8'h01);
        rd_chk(fste_pkg::OFS_STATUS, 8'h01);
        chk8({7'h0, irq}, 8'h01);
        wr_reg(fste_pkg::OFS_STATUS, 8'h00);
        rd_chk(fste_pkg::OFS_STATUS, 8'h01);
        wr_reg(fste_pkg::OFS_STATUS, 8'h01);
        rd_chk(fste_pkg::OFS_STATUS, 8'h00);
        chk8({7'h0, irq}, 8'h00);
        repeat (SPIN) @(posedge clk);
        #1 chk8({7'h0, spin}, 8'h00);
        rd_chk(fste_pkg::OFS_STATUS, 8'h02);
        wr_reg(fste_pkg::OFS_CLEAR, 8'h02);
        rd_chk(fste_pkg::OFS_STATUS, 8'h00);
    endtask
    // a result every 800 cycles; at most 14 by 56 half periods, at least 16 by 70
    task automatic t_shortfall;
        wr_reg(fste_pkg::OFS_LIMIT, 8'hff);
        wr_reg(fste_pkg::OFS_IRQ_EN, 8'h20);
        drive <= fste_pkg::DRIVE_FULL;
        half <= 16'd200;
        run <= 1'b1;
        repeat (56 * 200) @(posedge clk);
        rd_chk(fste_pkg::OFS_STATUS, 8'h00);
        repeat (14 * 200) @(posedge clk);
        rd_chk(fste_pkg::OFS_STATUS, 8'h20);
        chk8({7'h0, irq}, 8'h01);
        run <= 1'b0;
        wr_reg(fste_pkg::OFS_CLEAR, 8'h20);
        rd_chk(fste_pkg::OFS_STATUS, 8'h00);
    endtask
    // ==========================================================
    // sequence and watchdog
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wd = 8'h00;
        drive = 8'h00;
        run = 1'b0;
        half = 16'd400;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_edges();
        t_stall_spin();
        t_shortfall();
        give_verdict();
    end
    // the tests take about 60000 cycles; a hang is cut off well past that
    initial begin
        repeat (90000) @(posedge clk);
        fails++;
        give_verdict();
    end
endmodule // testbench
